// ### bench/modem_model.sv
/*
 * Behavioural modem on the far side of the serial pins.
 * Assumes the bench commands which lines are asserted; idle is mark/high.
 */
`timescale 1ns/1ns
`default_nettype none

module modem_model (
	// commanded line states, active high
	input wire logic [3:0] assert_i,
	input wire logic space_i,
	// pins toward the port
	output logic rxd_o,
	output logic clear_send_in_n,
	output logic set_ready_in_n,
	output logic ring_in_n,
	output logic carrier_detect_in_n
);
	// the line falls back to mark once a break is dropped
	assign rxd_o = ~space_i;
	assign {carrier_detect_in_n, ring_in_n, set_ready_in_n,
		clear_send_in_n} = ~assert_i;
endmodule : modem_model

`default_nettype wire

// ### bench/testbench.sv
/*
 * Self-checking bench for the modem control and status register block.
 * Assumes one 25 MHz clock and host strobes driven right after rising edges.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import uart_mls_pkg::*;
	logic clk_sys_i, nrst_i, tick, irq_o, irq_oe_o, txd_o, rxd;
	logic fifo_mode, avail, ferr, tx_out, ld, hw, fempty, sempty, pirq;
	logic rx_serial, rx_en, brk, ls_irq, ms_irq, dtr_n, rts_n;
	logic cts_n, dsr_n, ri_n, dcd_n, space;
	logic [3:0] asrt;
	logic [7:0] rdata;
	host_req_t host;
	rx_event_t ev;
	int failures, n_compared;

	uart_modem_line_status u_uart_modem_line_status (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .ce_i(1'b1), .host_i(host), .rdata_o(rdata),
		.fifo_mode_i(fifo_mode), .rx_data_avail_i(avail), .rx_ev_i(ev),
		.fifo_err_i(ferr), .sample_tick_i(tick), .char_bits_i(4'hA),
		.rx_serial_o(rx_serial), .rx_enable_o(rx_en), .rx_resync_o(),
		.brk_detect_o(brk), .tx_shift_out_i(tx_out), .tx_load_shift_i(ld),
		.tx_holding_write_i(hw), .tx_fifo_empty_i(fempty),
		.tx_shift_empty_i(sempty), .ls_irq_en_i(1'b1), .ms_irq_en_i(1'b1),
		.port_irq_i(pirq), .ls_irq_o(ls_irq), .ms_irq_o(ms_irq),
		.irq_o(irq_o), .irq_oe_o(irq_oe_o), .rxd_i(rxd),
		.clear_send_in_n(cts_n), .set_ready_in_n(dsr_n), .ring_in_n(ri_n),
		.carrier_detect_in_n(dcd_n), .txd_o(txd_o),
		.terminal_ready_out_n(dtr_n), .request_send_out_n(rts_n));

	modem_model u_modem_model (.assert_i(asrt), .space_i(space),
		.rxd_o(rxd), .clear_send_in_n(cts_n), .set_ready_in_n(dsr_n),
		.ring_in_n(ri_n), .carrier_detect_in_n(dcd_n));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) host <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys_i) host.wr <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i) host <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys_i) host.rd <= 1'b0;
		@(negedge clk_sys_i) check(rdata, exp);
	endtask : rd

	task automatic pulse(input rx_event_t e);
		@(posedge clk_sys_i) ev <= e;
		@(posedge clk_sys_i) ev <= '0;
		@(negedge clk_sys_i);
	endtask : pulse

	task automatic settle();
		repeat (5) @(negedge clk_sys_i);
	endtask : settle

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i) tick <= ~tick;

	initial begin
		#400000;
		failures++;
		finish_test();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		{failures, n_compared} = '0;
		{host, ev, tick, fifo_mode, avail, ferr, tx_out, ld, hw} = '0;
		{pirq, asrt, space} = '0;
		{fempty, sempty} = 2'b11;
		nrst_i = 1'b0;
		repeat (3) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rd(ADDR_MODEM_CONTROL, 8'h00);
		rd(ADDR_SCRATCH, SCRATCH_RESET);
		rd(ADDR_LINE_STATUS, 8'h60);
		rd(ADDR_MODEM_STATUS, 8'h00);
		rd(3'h0, READ_NONE);
		$display("reset values done");
		pirq <= 1'b1;
		wr(ADDR_MODEM_CONTROL, 8'hEB);
		rd(ADDR_MODEM_CONTROL, 8'h0B);
		check({dtr_n, rts_n, irq_oe_o, irq_o}, 4'h3);
		wr(ADDR_MODEM_CONTROL, 8'h04);
		rd(ADDR_MODEM_CONTROL, 8'h04);
		check({dtr_n, rts_n, irq_oe_o}, 3'h6);
		wr(ADDR_SCRATCH, 8'hA5);
		wr(ADDR_SCRATCH, 8'h5A);
		rd(ADDR_SCRATCH, 8'h5A);
		$display("control and scratch done");
		pulse(4'b1110);
		check(ls_irq, 1'b1);
		rd(ADDR_LINE_STATUS, 8'h6E);
		rd(ADDR_LINE_STATUS, 8'h60);
		check(ls_irq, 1'b0);
		avail <= 1'b1;
		sempty <= 1'b0;
		rd(ADDR_LINE_STATUS, 8'h21);
		pulse(4'b0100);
		rd(ADDR_LINE_STATUS, 8'h25);
		avail <= 1'b0;
		hw <= 1'b1;
		pulse(4'b0000);
		hw <= 1'b0;
		sempty <= 1'b1;
		rd(ADDR_LINE_STATUS, 8'h00);
		ld <= 1'b1;
		pulse(4'b0000);
		ld <= 1'b0;
		rd(ADDR_LINE_STATUS, 8'h60);
		fifo_mode <= 1'b1;
		ferr <= 1'b1;
		pulse(4'b0001);
		rd(ADDR_LINE_STATUS, 8'hF0);
		rd(ADDR_LINE_STATUS, 8'hE0);
		ferr <= 1'b0;
		rd(ADDR_LINE_STATUS, 8'hE0);
		rd(ADDR_LINE_STATUS, 8'h60);
		fifo_mode <= 1'b0;
		$display("line status done");
		space <= 1'b1;
		for (int i = 0; i < 1000 && brk !== 1'b1; i++)
			@(negedge clk_sys_i);
		check(brk, 1'b1);
		rd(ADDR_LINE_STATUS, 8'h70);
		check(rx_en, 1'b0);
		space <= 1'b0;
		repeat (40) @(negedge clk_sys_i);
		check(rx_en, 1'b1);
		rd(ADDR_LINE_STATUS, 8'h60);
		$display("break done");
		asrt <= 4'b0001;
		settle();
		rd(ADDR_MODEM_STATUS, 8'h11);
		asrt <= 4'b0100;
		settle();
		rd(ADDR_MODEM_STATUS, 8'h41);
		asrt <= 4'b0000;
		settle();
		check(ms_irq, 1'b1);
		rd(ADDR_MODEM_STATUS, 8'h04);
		rd(ADDR_MODEM_STATUS, 8'h00);
		$display("modem status done");
		asrt <= 4'b1111;
		space <= 1'b1;
		wr(ADDR_MODEM_CONTROL, 8'h1F);
		settle();
		check({txd_o, dtr_n, rts_n, rx_serial}, 4'hE);
		tx_out <= 1'b1;
		settle();
		check(rx_serial, 1'b1);
		check(ms_irq, 1'b1);
		rd(ADDR_MODEM_STATUS, 8'hFB);
		rd(ADDR_MODEM_STATUS, 8'hF0);
		wr(ADDR_MODEM_CONTROL, 8'h12);
		settle();
		rd(ADDR_MODEM_STATUS, 8'h1E);
		{asrt, space} <= '0;
		wr(ADDR_MODEM_CONTROL, 8'h00);
		settle();
		rd(ADDR_MODEM_STATUS, 8'h01);
		$display("loopback done");
		finish_test();
	end
endmodule : testbench

`default_nettype wire

// ### src/uart_mls_pkg.sv
/*
 * Shared constants and carrier types for the modem control, line status,
 * modem status and scratch register block of a 16550-style serial port.
 * Assumes an 8-bit host register port with a 3-bit register index.
 */
package uart_mls_pkg;

	// ****************************************
	// register index
	// ****************************************
	localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
	localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;

	// ****************************************
	// modem control fields
	// ****************************************
	localparam int MC_TERM_READY = 0;
	localparam int MC_REQ_SEND = 1;
	localparam int MC_AUX_ONE = 2;
	localparam int MC_AUX_TWO = 3;
	localparam int MC_LOOPBACK = 4;
	localparam int MC_WIDTH = 5;
	localparam logic [4:0] MC_RESET = 5'h0;
	localparam logic [2:0] MC_UNUSED_READ = 3'h0;
	localparam logic [7:0] SCRATCH_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	// ****************************************
	// line timing, in 16x sample ticks
	// ****************************************
	localparam logic [3:0] TICKS_SHIFT = 4'h0;
	localparam logic [8:0] HALF_BIT_TICKS = 9'h008;
	localparam logic [8:0] CNT_ZERO = 9'h000;
	localparam logic [8:0] CNT_ONE = 9'h001;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} host_req_t;

	// events from the receiver; in fifo mode they describe the fifo top
	typedef struct packed {
		logic overrun;
		logic parity;
		logic framing;
		logic brk;
	} rx_event_t;

	typedef enum logic [2:0] {
		BRK_IDLE = 3'b001,
		BRK_LOW = 3'b010,
		BRK_HOLD = 3'b100
	} brk_state_t;

	typedef struct packed {
		logic [4:0] modem_control;
		logic [7:0] scratch;
		logic oe;
		logic pe;
		logic fe;
		logic bi;
		logic err7;
		logic tx_holding_empty;
		logic [3:0] dmsr;
		logic [3:0] mprev;
		logic [4:0] sy1;
		logic [4:0] sy2;
		logic [7:0] rdata;
		brk_state_t bst;
		logic [8:0] cnt;
	} state_t;

endpackage : uart_mls_pkg

// ### src/uart_modem_line_status.sv
/*
 * Modem control, line status, modem status and scratch registers with
 * loopback routing and break monitoring for one 16550-style serial port.
 * Assumes a receiver, transmitter and interrupt identifier on the same
 * clock that supply the event and level inputs below.
 */
`timescale 1ns/1ns
`default_nettype none

module uart_modem_line_status (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// host register port
	input wire uart_mls_pkg::host_req_t host_i,
	output logic [7:0] rdata_o,
	// receiver side
	input wire logic fifo_mode_i,
	input wire logic rx_data_avail_i,
	input wire uart_mls_pkg::rx_event_t rx_ev_i,
	input wire logic fifo_err_i,
	input wire logic sample_tick_i,
	input wire logic [3:0] char_bits_i,
	output logic rx_serial_o,
	output logic rx_enable_o,
	output logic rx_resync_o,
	output logic brk_detect_o,
	// transmitter side
	input wire logic tx_shift_out_i,
	input wire logic tx_load_shift_i,
	input wire logic tx_holding_write_i,
	input wire logic tx_fifo_empty_i,
	input wire logic tx_shift_empty_i,
	// interrupt side
	input wire logic ls_irq_en_i,
	input wire logic ms_irq_en_i,
	input wire logic port_irq_i,
	output logic ls_irq_o,
	output logic ms_irq_o,
	output logic irq_o,
	output logic irq_oe_o,
	// serial pins
	input wire logic rxd_i,
	input wire logic clear_send_in_n,
	input wire logic set_ready_in_n,
	input wire logic ring_in_n,
	input wire logic carrier_detect_in_n,
	output logic txd_o,
	output logic terminal_ready_out_n,
	output logic request_send_out_n
);
	import uart_mls_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// set beats clear so that an event in the read cycle is kept
	function automatic logic sticky(input logic cur, input logic set,
		input logic clr);
		sticky = set | (cur & ~clr);
	endfunction : sticky

	function automatic logic [3:0] sticky4(input logic [3:0] cur,
		input logic [3:0] set, input logic clr);
		sticky4 = set | (cur & ~{4{clr}});
	endfunction : sticky4

	state_t s;
	state_t next_s;
	logic loop;
	logic line;
	logic [3:0] m_act;
	logic [3:0] m_ev;
	logic rd_ls;
	logic rd_ms;
	logic ls5;
	logic ls6;
	logic ls7;
	logic [7:0] ls_val;
	logic [7:0] ms_val;
	logic [8:0] brk_limit;
	logic brk_pulse;

	// ****************************************
	// routing
	// ****************************************
	assign loop = s.modem_control[MC_LOOPBACK];
	// second sync stage only; first stage feeds nothing else
	assign line = loop ? tx_shift_out_i : s.sy2[0];
	assign rx_serial_o = line;
	assign txd_o = loop ? 1'b1 : tx_shift_out_i;
	assign terminal_ready_out_n = loop ? 1'b1 : ~s.modem_control[MC_TERM_READY];
	assign request_send_out_n = loop ? 1'b1 : ~s.modem_control[MC_REQ_SEND];
	assign irq_o = port_irq_i;
	assign irq_oe_o = s.modem_control[MC_AUX_TWO];

	// active-high view: clear-send, set-ready, ring, carrier
	always_comb begin
		if (loop) begin
			m_act = {s.modem_control[MC_AUX_TWO], s.modem_control[MC_AUX_ONE], s.modem_control[MC_TERM_READY],
				s.modem_control[MC_REQ_SEND]};
		end else begin
			m_act = ~s.sy2[4:1];
		end
	end

	// ring only counts when it goes away
	assign m_ev = {m_act[3] ^ s.mprev[3], s.mprev[2] & ~m_act[2],
		m_act[1] ^ s.mprev[1], m_act[0] ^ s.mprev[0]};

	// ****************************************
	// status views
	// ****************************************
	assign rd_ls = host_i.rd && (host_i.addr == ADDR_LINE_STATUS);
	assign rd_ms = host_i.rd && (host_i.addr == ADDR_MODEM_STATUS);
	assign ls5 = fifo_mode_i ? tx_fifo_empty_i : s.tx_holding_empty;
	assign ls6 = ls5 & tx_shift_empty_i;
	assign ls7 = fifo_mode_i & s.err7;
	assign ls_val = {ls7, ls6, ls5, s.bi, s.fe, s.pe, s.oe,
		rx_data_avail_i};
	assign ms_val = {m_act, s.dmsr};
	assign ls_irq_o = ls_irq_en_i & (s.oe | s.pe | s.fe | s.bi);
	assign ms_irq_o = ms_irq_en_i & (|s.dmsr);
	assign rdata_o = s.rdata;

	// ****************************************
	// break monitor
	// ****************************************
	// a break outlasts a whole frame of start, data, parity and stop
	assign brk_limit = {1'b0, char_bits_i, TICKS_SHIFT};
	assign brk_pulse = (s.bst == BRK_LOW) && sample_tick_i &&
		(s.cnt > brk_limit);
	assign brk_detect_o = brk_pulse;
	// receiver is held off until the line has been high half a bit,
	// which also keeps a break to a single zero character
	assign rx_enable_o = (s.bst != BRK_HOLD);
	// a framing error with the line still low means that low is the
	// next start bit; the receiver samples it twice and carries on
	assign rx_resync_o = rx_ev_i.framing & ~line;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.sy1 = {carrier_detect_in_n, ring_in_n, set_ready_in_n,
			clear_send_in_n, rxd_i};
		next_s.sy2 = s.sy1;
		next_s.mprev = m_act;

		// register writes
		if (host_i.wr) begin
			case (host_i.addr)
				ADDR_MODEM_CONTROL: next_s.modem_control = host_i.wdata[MC_WIDTH-1:0];
				ADDR_SCRATCH: next_s.scratch = host_i.wdata;
				default: ;
			endcase
		end

		// read data, captured before the clears below take effect
		next_s.rdata = READ_NONE;
		if (host_i.rd) begin
			case (host_i.addr)
				ADDR_MODEM_CONTROL: next_s.rdata = {MC_UNUSED_READ, s.modem_control};
				ADDR_LINE_STATUS: next_s.rdata = ls_val;
				ADDR_MODEM_STATUS: next_s.rdata = ms_val;
				ADDR_SCRATCH: next_s.rdata = s.scratch;
				default: next_s.rdata = READ_NONE;
			endcase
		end

		// line status flags
		next_s.oe = sticky(s.oe, rx_ev_i.overrun, rd_ls);
		next_s.pe = sticky(s.pe, rx_ev_i.parity, rd_ls);
		next_s.fe = sticky(s.fe, rx_ev_i.framing, rd_ls);
		next_s.bi = sticky(s.bi, rx_ev_i.brk | (brk_pulse & ~fifo_mode_i),
			rd_ls);
		next_s.err7 = fifo_mode_i & sticky(s.err7, fifo_err_i, rd_ls);
		next_s.tx_holding_empty = sticky(s.tx_holding_empty, tx_load_shift_i,
			tx_holding_write_i);

		// modem deltas
		next_s.dmsr = sticky4(s.dmsr, m_ev, rd_ms);

		// break monitor
		case (s.bst)
			BRK_IDLE: begin
				next_s.cnt = CNT_ZERO;
				if (sample_tick_i && !line) begin
					next_s.bst = BRK_LOW;
					next_s.cnt = CNT_ONE;
				end
			end
			BRK_LOW: begin
				if (line) begin
					next_s.bst = BRK_IDLE;
					next_s.cnt = CNT_ZERO;
				end else if (brk_pulse) begin
					next_s.bst = BRK_HOLD;
					next_s.cnt = CNT_ZERO;
				end else if (sample_tick_i) begin
					next_s.cnt = s.cnt + CNT_ONE;
				end
			end
			BRK_HOLD: begin
				if (!line) begin
					next_s.cnt = CNT_ZERO;
				end else if (sample_tick_i) begin
					if (s.cnt + CNT_ONE >= HALF_BIT_TICKS) begin
						next_s.bst = BRK_IDLE;
						next_s.cnt = CNT_ZERO;
					end else begin
						next_s.cnt = s.cnt + CNT_ONE;
					end
				end
			end
			default: begin
				next_s.bst = BRK_IDLE;
				next_s.cnt = CNT_ZERO;
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s.modem_control <= MC_RESET;
			s.scratch <= SCRATCH_RESET;
			s.oe <= 1'b0;
			s.pe <= 1'b0;
			s.fe <= 1'b0;
			s.bi <= 1'b0;
			s.err7 <= 1'b0;
			s.tx_holding_empty <= 1'b1;
			s.dmsr <= 4'h0;
			s.mprev <= 4'h0;
			s.sy1 <= 5'h1F;
			s.sy2 <= 5'h1F;
			s.rdata <= READ_NONE;
			s.bst <= BRK_IDLE;
			s.cnt <= CNT_ZERO;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	term_ready_pin_a: assert property (
		!loop |-> (terminal_ready_out_n == !s.modem_control[MC_TERM_READY]))
		else $error("terminal ready pin does not follow control bit 0");
	req_send_pin_a: assert property (
		ce_i && host_i.wr && host_i.addr == ADDR_MODEM_CONTROL &&
		!host_i.wdata[MC_LOOPBACK] |=> (request_send_out_n ==
		!$past(host_i.wdata[MC_REQ_SEND])))
		else $error("request send pin does not follow written bit 1");
	irq_gate_a: assert property (
		ce_i && host_i.wr && host_i.addr == ADDR_MODEM_CONTROL |=>
		(irq_oe_o == $past(host_i.wdata[MC_AUX_TWO])))
		else $error("interrupt enable does not follow written bit 3");
	loop_pins_a: assert property (
		loop |-> (txd_o && terminal_ready_out_n && request_send_out_n &&
		rx_serial_o == tx_shift_out_i))
		else $error("loopback pins not forced");
	mcr_read_a: assert property (
		ce_i && host_i.rd && host_i.addr == ADDR_MODEM_CONTROL |=>
		(rdata_o[7:5] == 3'h0 && rdata_o[4:0] == $past(s.modem_control)))
		else $error("modem control read wrong");
	overrun_clear_a: assert property (
		ce_i && rd_ls && !rx_ev_i.overrun |=> !s.oe)
		else $error("overrun not cleared by status read");
	overrun_keep_a: assert property (
		ce_i && rd_ls && rx_ev_i.overrun |=> s.oe ##1 (s.oe || $past(rd_ls)))
		else $error("overrun lost during status read");
	delta_set_a: assert property (
		ce_i && m_ev[0] |=> s.dmsr[0] && (ms_irq_o == ms_irq_en_i))
		else $error("clear send change not captured");
	tx_all_empty_a: assert property (
		ls6 |-> (ls5 && tx_shift_empty_i))
		else $error("transmitter empty with data present");
	scratch_a: assert property (
		ce_i && host_i.wr && host_i.addr == ADDR_SCRATCH ##1
		ce_i && host_i.rd && host_i.addr == ADDR_SCRATCH && !host_i.wr
		|=> rdata_o == $past(host_i.wdata, 2))
		else $error("scratch value not returned");
	break_hold_a: assert property (
		brk_pulse && ce_i |=> !rx_enable_o [*2])
		else $error("receiver not held after break");

	// ****************************************
	// checks on status and loopback
	// ****************************************
	// read-back checks look at the registered data, one cycle on
	aux_one_store_a: assert property (
		ce_i && host_i.wr && host_i.addr == ADDR_MODEM_CONTROL |=>
		(s.modem_control[MC_AUX_ONE] == $past(host_i.wdata[MC_AUX_ONE])))
		else $error("auxiliary bit one not stored");
	loop_entry_a: assert property (
		ce_i && host_i.wr && host_i.addr == ADDR_MODEM_CONTROL &&
		host_i.wdata[MC_LOOPBACK] |=> (txd_o && terminal_ready_out_n))
		else $error("pins not forced on loopback entry");
	loop_status_a: assert property (
		ce_i && rd_ms && loop |=> (rdata_o[7:4] ==
		$past({s.modem_control[3], s.modem_control[2], s.modem_control[0], s.modem_control[1]})))
		else $error("loopback modem status wrong");
	loop_irq_a: assert property (
		ce_i && loop && (|m_ev) |=> (ms_irq_o == ms_irq_en_i))
		else $error("loopback modem interrupt missing");
	ms_clear_a: assert property (
		ce_i && rd_ms && !(|m_ev) |=> (s.dmsr == 4'h0))
		else $error("modem deltas not cleared by read");
	ring_quiet_a: assert property (
		ce_i && !m_ev[2] && !s.dmsr[2] |=> !s.dmsr[2])
		else $error("ring delta set without trailing edge");
	tx_holding_empty_set_a: assert property (
		ce_i && tx_load_shift_i |=> s.tx_holding_empty)
		else $error("holding empty not set on shift load");
	tx_holding_empty_clr_a: assert property (
		ce_i && tx_holding_write_i && !tx_load_shift_i |=> !s.tx_holding_empty)
		else $error("holding empty not cleared on write");
	fifo_tx_holding_empty_a: assert property (
		ce_i && rd_ls && fifo_mode_i |=> (rdata_o[5] == $past(tx_fifo_empty_i)))
		else $error("fifo holding empty not reported");
	err7_zero_a: assert property (
		ce_i && rd_ls && !fifo_mode_i |=> !rdata_o[7])
		else $error("status bit 7 set outside fifo mode");
	data_ready_a: assert property (
		ce_i && rd_ls |=> (rdata_o[0] == $past(rx_data_avail_i)))
		else $error("data ready not reported");
	brk_wait_a: assert property (
		ce_i && s.bst == BRK_HOLD && !line |=> !rx_enable_o)
		else $error("receiver released while line low");
	ls_irq_a: assert property (
		ce_i && rx_ev_i.parity |=> (ls_irq_o == ls_irq_en_i))
		else $error("line status interrupt missing");
	parity_clear_a: assert property (
		ce_i && rd_ls && !rx_ev_i.parity |=> !s.pe)
		else $error("parity error not cleared by read");
	framing_clear_a: assert property (
		ce_i && rd_ls && !rx_ev_i.framing |=> !s.fe)
		else $error("framing error not cleared by read");

	loop_cov: cover property (ce_i && loop && |m_ev);
	break_cov: cover property (brk_pulse && ce_i);
	ls_read_cov: cover property (rd_ls && ce_i && (s.pe || s.fe));
	ring_cov: cover property (ce_i && m_ev[2]);
	tx_holding_empty_cov: cover property (ce_i && tx_load_shift_i);

endmodule : uart_modem_line_status

`default_nettype wire
